// *** test/autoinc_monitor.sv ***
`timescale 1ns/1ps
module autoinc_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_mode,
    input wire logic addr_load,
    input wire logic [7:0] addr_value,
    input wire logic read_strobe,
    input wire logic burst_mode,
    input wire logic stop_seen,
    input wire logic [1:0] fifo_mode,
    input wire logic [7:0] fifo_status,
    input wire logic [7:0] reg_pointer,
    input wire logic [7:0] read_data,
    input wire logic read_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // pointer and read data are zero when reset lets go
    property p_rst; $fell(rst) |-> reg_pointer == 8'h00 && read_data == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("pointer or data not zero after reset");
    property p_step; read_strobe && burst_mode && !addr_load && reg_pointer inside {[8'h5B:8'h78]}
        |=> reg_pointer == $past(reg_pointer) + 8'h01; endproperty
    a_step: assert property (p_step) else $error("pointer did not step");
    property p_single; read_strobe && !burst_mode && !addr_load |=> $stable(reg_pointer); endproperty
    a_single: assert property (p_single) else $error("pointer moved on single read");
    property p_stop; stop_seen && !spi_mode && !addr_load && !read_strobe |=> reg_pointer == 8'h00; endproperty
    a_stop: assert property (p_stop) else $error("stop did not clear pointer");
    property p_spi; stop_seen && spi_mode && !addr_load && !read_strobe |=> $stable(reg_pointer); endproperty
    a_spi: assert property (p_spi) else $error("pointer cleared in spi mode");
    property p_fifo; read_strobe && !addr_load && reg_pointer == 8'h00 && fifo_mode != 2'h0
        |=> read_valid && read_data == $past(fifo_status); endproperty
    a_fifo: assert property (p_fifo) else $error("fifo view not returned");
    property p_end; read_strobe && !addr_load && reg_pointer == 8'h79 |=> reg_pointer == 8'h79; endproperty
    a_end: assert property (p_end) else $error("pointer left reserved address");
    property p_answer; read_strobe && !addr_load |=> read_valid; endproperty
    a_answer: assert property (p_answer) else $error("read valid missing after read");
    property p_lone; !read_strobe || addr_load |=> !read_valid; endproperty
    a_lone: assert property (p_lone) else $error("read valid without a read");
    property p_idle; !addr_load && !read_strobe && !stop_seen |=> $stable(reg_pointer); endproperty
    a_idle: assert property (p_idle) else $error("pointer moved with no request");
    property p_load; addr_load |=> reg_pointer == $past(addr_value); endproperty
    a_load: assert property (p_load) else $error("pointer not loaded");
endmodule // autoinc_monitor
bind burst_read_address_autoinc autoinc_monitor autoinc_monitor_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .spi_mode(spi_mode),
    .addr_load(addr_load),
    .addr_value(addr_value),
    .read_strobe(read_strobe),
    .burst_mode(burst_mode),
    .stop_seen(stop_seen),
    .fifo_mode(fifo_mode),
    .fifo_status(fifo_status),
    .reg_pointer(reg_pointer),
    .read_data(read_data),
    .read_valid(read_valid)
);

// *** test/burst_read_address_autoinc_bench.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end
module burst_read_address_autoinc_bench;
    logic sys_clk = 0, rst = 1, spi_mode = 0, addr_load = 0, read_strobe = 0, burst_mode = 1, stop_seen = 0;
    logic fast_read = 0, read_valid;
    logic [7:0] addr_value = 8'h00, fifo_status = 8'h00, reg_read_data, reg_pointer, read_data, rng = 8'h0E;
    logic [7:0] base_addr = 8'h00;
    logic [1:0] fifo_mode = 2'h0;
    logic [2:0] new_sample = 3'h0, msb_read = 3'h0;
    int fail_count = 0, samples_checked = 0;
    always #50 sys_clk = ~sys_clk;
    burst_read_address_autoinc burst_read_address_autoinc_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .spi_mode(spi_mode),
        .addr_load(addr_load),
        .addr_value(addr_value),
        .read_strobe(read_strobe),
        .burst_mode(burst_mode),
        .stop_seen(stop_seen),
        .fifo_mode(fifo_mode),
        .fast_read(fast_read),
        .reg_read_data(reg_read_data),
        .fifo_status(fifo_status),
        .new_sample(new_sample),
        .msb_read(msb_read),
        .reg_pointer(reg_pointer),
        .read_data(read_data),
        .read_valid(read_valid)
    );
    host_register_model host_register_model_inst (.reg_pointer(reg_pointer), .reg_read_data(reg_read_data));
    function automatic logic [7:0] xs(input logic [7:0] v);
        v ^= v << 3;
        v ^= v >> 5;
        return v ^ (v << 1);
    endfunction
    // expected burst successor: only the configuration range steps
    function automatic logic [7:0] exp_next(input logic [7:0] a);
        return (a >= 8'h5B && a <= 8'h78) ? 8'(a + 8'h01) : a;
    endfunction
    // expected data-ready view from per-axis overwrite and ready bits
    function automatic logic [7:0] exp_view(input logic [2:0] ow, input logic [2:0] dr);
        return {|ow, ow, &dr, dr};
    endfunction
    // one strobed read; the answer lands one cycle later
    task rd(input logic [7:0] e);
        @(negedge sys_clk) read_strobe = 1;
        @(negedge sys_clk) read_strobe = 0;
        `CHK("valid", 1'b1, read_valid)
        `CHK("data", e, read_data)
    endtask
    task ld(input logic [7:0] a);
        @(negedge sys_clk) addr_load = 1;
        addr_value = a;
        @(negedge sys_clk) addr_load = 0;
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchdog: a hang counts as a mismatch
    initial begin
        #1000000 fail_count++;
        final_report;
    end
    initial begin
        repeat (2) @(negedge sys_clk);
        rst = 0;
        rd(8'h00);
        ld(8'h5B);
        for (int a = 8'h5B; a <= 8'h79; a++) begin
            rd(a[7:0] ^ 8'hA5);
            `CHK("ptr", exp_next(a[7:0]), reg_pointer)
        end
        stop_seen = 1;
        @(negedge sys_clk) stop_seen = 0;
        `CHK("ptr", 8'h00, reg_pointer)
        spi_mode = 1;
        ld(8'h60);
        stop_seen = 1;
        @(negedge sys_clk) stop_seen = 0;
        `CHK("ptr", 8'h60, reg_pointer)
        burst_mode = 0;
        rd(8'h60 ^ 8'hA5);
        `CHK("ptr", 8'h60, reg_pointer)
        // random start points; with this seed all eight land inside the range, between 0x60 and 0x76
        repeat (8) begin
            rng = xs(rng);
            base_addr = 8'h60 + {3'h0, rng[4:0]};
            burst_mode = rng[5];
            ld(base_addr);
            rd(base_addr ^ 8'hA5);
            `CHK("ptr", burst_mode ? exp_next(base_addr) : base_addr, reg_pointer)
        end
        burst_mode = 0;
        ld(8'h00);
        repeat (4) begin
            rng = xs(rng);
            fifo_status = rng;
            fifo_mode = (rng[1:0] == 2'h0) ? 2'h2 : rng[1:0];
            fast_read = rng[2];
            rd(rng);
        end
        fifo_mode = 2'h0;
        new_sample = 3'h1;
        repeat (2) @(negedge sys_clk);
        new_sample = 3'h0;
        rd(exp_view(3'h1, 3'h1));
        msb_read = 3'h1;
        @(negedge sys_clk) msb_read = 3'h0;
        rd(8'h00);
        // all flags set, then a mid-run reset must clear them and the pointer
        new_sample = 3'h7;
        repeat (2) @(negedge sys_clk);
        new_sample = 3'h0;
        rd(exp_view(3'h7, 3'h7));
        ld(8'h65);
        rst = 1;
        @(negedge sys_clk) rst = 0;
        `CHK("ptr", 8'h00, reg_pointer)
        rd(8'h00);
        // a new sample and an msb read in one cycle: the set wins
        new_sample = 3'h2;
        @(negedge sys_clk) msb_read = 3'h2;
        @(negedge sys_clk) new_sample = 3'h0;
        msb_read = 3'h0;
        rd(exp_view(3'h2, 3'h2));
        final_report;
    end
endmodule // burst_read_address_autoinc_bench

// *** test/host_register_model.sv ***
`timescale 1ns/1ps
// far-side register contents: a fixed pattern per address, so a wrong pointer shows in the data
module host_register_model (
    input wire logic [7:0] reg_pointer,
    output logic [7:0] reg_read_data
);
    assign reg_read_data = reg_pointer ^ 8'hA5;
endmodule // host_register_model

// *** verilog/autoinc_pkg.sv ***
package autoinc_pkg;
    // register addresses, status reset value and fifo-off mode code
    localparam logic [7:0] addr_status = 8'h00;
    localparam logic [7:0] addr_upper_first = 8'h5B;
    localparam logic [7:0] addr_upper_last = 8'h78;
    localparam logic [7:0] addr_reserved = 8'h79;
    localparam logic [7:0] status_reset = 8'h00;
    localparam logic [1:0] fifo_mode_off = 2'h0;
    // overwrite flag and data-ready summary positions in the data-ready view
    localparam int ow_x_bit = 4;
    localparam int ow_y_bit = 5;
    localparam int ow_z_bit = 6;
    localparam int ow_any_bit = 7;
    localparam int dr_any_bit = 3;
endpackage

// *** verilog/burst_read_address_autoinc.sv ***
// Behaviour
// - in burst read, pointer steps after each register 0x5B through 0x78.
// - pointer steps only on burst reads, in I2C or SPI.
// - I2C stop returns the pointer to 0x00.
// - SPI mode never clears the pointer between transactions.
// - address 0x00 is an 8-bit read-only status register resetting to zero.
// - address 0x00 shows data-ready view if fifo mode 00, else fifo view.
// - a burst from 0x00 rereads the status byte and never reaches data, in both 8-bit and 14-bit read modes.
// - overwrite flags set on unread replacement, clear on that axis msb read.
`timescale 1ns/1ps
module burst_read_address_autoinc (
    // clock and synchronous reset
    input wire logic sys_clk,
    input wire logic rst,
    // link kind: high for SPI, low for I2C
    input wire logic spi_mode,
    // pointer load and read requests from the serial port
    input wire logic addr_load,
    input wire logic [7:0] addr_value,
    input wire logic read_strobe,
    input wire logic burst_mode,
    input wire logic stop_seen,
    // status sources, read width and far-side register contents
    input wire logic [1:0] fifo_mode,
    input wire logic fast_read,
    input wire logic [7:0] reg_read_data,
    input wire logic [7:0] fifo_status,
    input wire logic [2:0] new_sample,
    input wire logic [2:0] msb_read,
    // registered answers to the host
    output logic [7:0] reg_pointer,
    output logic [7:0] read_data,
    output logic read_valid
);
    // timing seen from the host: a request is taken at a rising edge and
    // its answer stands from that same edge on; read_valid marks read_data
    // for one cycle only, while read_data and the pointer hold until changed
    // requests may come back to back, one per cycle, with no wait state
    // limitation: the lower register map is not stepped here, so a burst
    // that starts below the configuration range rereads its first register
    // limitation: a stop that meets a read or a load in one cycle is lost

    // pointer regions that decide what a burst step does
    typedef enum logic [2:0] {
        region_status,
        region_lower,
        region_upper,
        region_reserved,
        region_beyond
    } region_t;

    // all remembered state sits in one registered struct, so reset and
    // update cover every bit in the same place
    typedef struct packed {
        logic [7:0] pointer; // register the next read returns
        logic [7:0] data; // byte handed back by the last read
        logic valid; // one-cycle mark on data
    } top_state_t;

    top_state_t state;
    top_state_t next_state;
    // alias byte from the status view selector
    logic [7:0] status_value;
    // request decode, one flag per action
    logic take_load;
    logic take_read;
    logic take_step;
    logic take_stop;
    // datapath helpers between decode and the state update
    region_t region;
    logic [7:0] step_target;
    logic [7:0] read_byte;

    // sort an address into the region that decides its burst successor;
    // reserved is tested before the range so it can never step
    function automatic region_t classify(input logic [7:0] a);
        if (a == autoinc_pkg::addr_status) begin
            return region_status;
        end
        if (a == autoinc_pkg::addr_reserved) begin
            return region_reserved;
        end
        if (a >= autoinc_pkg::addr_upper_first && a <= autoinc_pkg::addr_upper_last) begin
            return region_upper;
        end
        if (a > autoinc_pkg::addr_reserved) begin
            return region_beyond;
        end
        return region_lower;
    endfunction

    // successor of an address during a burst; only the configuration range
    // steps, everything else holds so a runaway burst cannot wrap to status
    function automatic logic [7:0] upper_next(input logic [7:0] a);
        logic [7:0] succ;
        succ = a;
        if (classify(a) == region_upper) begin
            succ = 8'(a + 8'h01);
        end
        return succ;
    endfunction

    // byte a read returns: the alias at address zero, else the far side;
    // the far side sees the same pointer, so no extra address path is needed
    function automatic logic [7:0] pick_byte(
        input logic [7:0] a,
        input logic [7:0] alias_byte,
        input logic [7:0] far_byte
    );
        if (a == autoinc_pkg::addr_status) begin
            return alias_byte;
        end
        return far_byte;
    endfunction

    // a stop only counts on the I2C link; SPI has no stop condition, so a
    // pointer left mid-range there is kept for the next transaction
    function automatic logic stop_applies(input logic stop, input logic spi);
        return stop && !spi;
    endfunction

    // the alias shows the data-ready or fifo view by the fifo mode field
    status_alias status_alias_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .new_sample(new_sample),
        .msb_read(msb_read),
        .fifo_mode(fifo_mode),
        .fifo_status(fifo_status),
        .status_value(status_value)
    );

    // request priority: load over read over stop; the host never asks for
    // two at once, but a stray overlap must still leave one clear winner
    // so the pointer is never written from two sources in one cycle
    always_comb begin
        take_load = addr_load;
        take_read = read_strobe && !addr_load;
        take_step = take_read && burst_mode;
        take_stop = stop_applies(stop_seen, spi_mode) && !addr_load && !read_strobe;
    end

    // region of the current pointer, kept apart so the step rule reads plainly
    always_comb begin
        region = classify(state.pointer);
    end

    // where a step lands; only the configuration range moves the pointer,
    // every other region but region_beyond is spelled out, and the default holds, so a new region cannot slip through
    always_comb begin
        step_target = state.pointer;
        case (region)
            region_upper: begin
                step_target = upper_next(state.pointer);
            end
            region_reserved: begin
                step_target = state.pointer;
            end
            region_status: begin
                step_target = state.pointer;
            end
            region_lower: begin
                step_target = state.pointer;
            end
            default: begin
                step_target = state.pointer;
            end
        endcase
    end

    // byte captured by a read; the alias is sampled at the strobe edge, so
    // the answer shows the flags as they stood when the host asked
    always_comb begin
        read_byte = pick_byte(state.pointer, status_value, reg_read_data);
    end

    // next state: load, read with an optional step, or a stop clear;
    // valid drops by default so a read answer lasts exactly one cycle
    always_comb begin
        next_state = state;
        next_state.valid = 1'b0;
        if (take_load) begin
            next_state.pointer = addr_value;
        end
        if (take_read) begin
            next_state.valid = 1'b1;
            next_state.data = read_byte;
        end
        if (take_step) begin
            next_state.pointer = step_target;
        end
        if (take_stop) begin
            next_state.pointer = autoinc_pkg::addr_status;
        end
        // reset last so it overrides any request in the same cycle
        if (rst) begin
            next_state.pointer = autoinc_pkg::addr_status;
            next_state.data = autoinc_pkg::status_reset;
            next_state.valid = 1'b0;
        end
    end

    // one register stage for all state, reset included
    always_ff @(posedge sys_clk) begin
        state <= next_state;
    end

    // every output comes straight from a flip-flop, so the host side sees
    // no combinational path from its own requests
    assign reg_pointer = state.pointer;
    assign read_data = state.data;
    assign read_valid = state.valid;

    // the read width only reshapes the lower map, which lives outside this
    // block; the alias and the upper stepping behave alike in both widths
    logic unused_fast;
    assign unused_fast = fast_read;
endmodule // burst_read_address_autoinc

// *** verilog/status_alias.sv ***
`timescale 1ns/1ps
module status_alias (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] new_sample,
    input wire logic [2:0] msb_read,
    input wire logic [1:0] fifo_mode,
    input wire logic [7:0] fifo_status,
    output logic [7:0] status_value
);
    typedef struct packed {
        logic [2:0] ready;
        logic [2:0] overwrite;
    } alias_state_t;

    alias_state_t state;
    alias_state_t next_state;
    logic [7:0] dr_view;

    // a new sample wins over a same-cycle msb read, so no overwrite is lost
    always_comb begin
        next_state = state;
        for (int i = 0; i < 3; i++) begin
            if (new_sample[i]) begin
                next_state.overwrite[i] = state.ready[i];
                next_state.ready[i] = 1'b1;
            end else if (msb_read[i]) begin
                next_state.overwrite[i] = 1'b0;
                next_state.ready[i] = 1'b0;
            end
        end
        if (rst) begin
            next_state = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        state <= next_state;
    end

    // assemble the data-ready view and pick the alias
    always_comb begin
        dr_view = {1'b0, state.overwrite, 1'b0, state.ready};
        dr_view[autoinc_pkg::ow_any_bit] = |state.overwrite;
        dr_view[autoinc_pkg::dr_any_bit] = &state.ready;
        if (fifo_mode == autoinc_pkg::fifo_mode_off) begin
            status_value = dr_view;
        end else begin
            status_value = fifo_status;
        end
    end
endmodule // status_alias
